// ### rtl/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // ----------------------------------------
    // Two-stage synchroniser
    // ----------------------------------------
    logic [WIDTH-1:0] meta;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ### rtl/lvds_ctrl_pkg.sv
package lvds_ctrl_pkg;

    // ----------------------------------------
    // Register indices (byte address = 4 * index)
    // ----------------------------------------
    localparam logic [11:0] IDX_PATTERN_CTRL = 12'h190;
    localparam logic [11:0] IDX_ENABLE = 12'h200;
    localparam logic [11:0] IDX_MODE = 12'h201;
    localparam logic [11:0] IDX_FRAME_LEN = 12'h202;
    localparam logic [11:0] IDX_SYNC_REQ = 12'h203;
    localparam logic [11:0] IDX_OUT_CTRL = 12'h204;
    localparam logic [11:0] IDX_FRAME_COUNT = 12'h20E;
    localparam logic [11:0] IDX_STATUS = 12'h20F;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_PATTERN_CTRL = 8'h1E;
    localparam logic [7:0] RST_ENABLE = 8'h01;
    localparam logic [7:0] RST_MODE = 8'h01;
    localparam logic [7:0] RST_FRAME_LEN = 8'h80;
    localparam logic [7:0] RST_SYNC_REQ = 8'h01;
    localparam logic [7:0] RST_OUT_CTRL = 8'h02;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int ENABLE_BIT = 0;
    localparam int WIDTH_LSB = 4;
    localparam int WIDTH_MSB = 5;
    localparam int INTERLEAVE_BIT = 2;
    localparam int ALIGN_BIT = 1;
    localparam int DEMUX_BIT = 0;
    localparam int SOFT_SYNC_N_BIT = 0;
    localparam int SYNC_SEL_LSB = 2;
    localparam int SYNC_SEL_MSB = 3;
    localparam int INV_A_BIT = 0;
    localparam int LANE_PAT_BIT = 4;
    localparam int INV_FIRST_DATA_BIT = 8;
    localparam int STAT_SYNC_BIT = 0;
    localparam int STAT_RUN_BIT = 1;

    // ----------------------------------------
    // Encodings
    // ----------------------------------------
    localparam logic [1:0] SYNC_SEL_SINGLE = 2'h0;
    localparam logic [1:0] SYNC_SEL_TSTAMP = 2'h1;
    localparam logic [1:0] SYNC_SEL_NONE = 2'h2;
    localparam logic [1:0] WIDTH_12 = 2'h0;
    localparam logic [1:0] WIDTH_11 = 2'h1;
    localparam logic [1:0] WIDTH_10 = 2'h2;
    localparam logic [11:0] MASK_12 = 12'hFFF;
    localparam logic [11:0] MASK_11 = 12'hFFE;
    localparam logic [11:0] MASK_10 = 12'hFFC;
    localparam logic [11:0] MASK_8 = 12'hFF0;
    localparam logic [3:0] BUSES_DEMUX1 = 4'h3;
    localparam logic [3:0] BUSES_DEMUX2 = 4'hF;

endpackage

// ### rtl/lvds_interface_control.sv
`timescale 1ns/1ps
// Operation
// R1 - Bus B inversion bit set flips bit 9 of each pattern word on B.
// R2 - Bus A inversion bit set flips bit 8 on bus A; resets zero.
// R3 - Software disables the interface before rewriting other configuration.
// R4 - Disabled interface: logic held reset, outputs off, clocks gated.
// R5 - Disabled interface holds frame counter reset; reference pulse ignored.
// R6 - Software sets calibration before enabling, disables before clearing it.
// R7 - Enable bit at bit 0, resets one, one enables, zero disables.
// R8 - Width field bits 5:4: 12, 11, 10 or 8 bits; resets 12.
// R9 - Mode bit 2: one interleaved single channel, zero dual channel.
// R10 - Software keeps calibration off while changing interleave selection.
// R11 - Mode bit 1: zero staggers buses, one aligns them.
// R12 - Mode bit 0: zero two buses, one four buses; resets one.
// R13 - Eight-bit frame length in unit intervals, multiples of four, resets 128.
// R14 - Frame strobe period equals the programmed frame length.
// R15 - Unit interval is one output clock, or two when demux bit set.
// R16 - Software avoids frame length four; latency may be nondeterministic.
// R17 - Writing zero to soft sync bit requests sync like the pin.
// R18 - Sync request is OR of soft bit and selected pin.
// R19 - Held-low selected pin keeps request unless source selects no pin.
// R20 - Source 0 single-ended pin, 1 timestamp pin, 2 no pin.
// R21 - Reserved bits store writes, reset zero, no effect.
module lvds_interface_control #(
    parameter int LANE_WIDTH = 12,
    parameter int BUSES = 4
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic link_clk,
    input wire logic sysref,
    input wire logic sync_se_n,
    input wire logic tmstp_sync_n,
    input wire logic [BUSES*LANE_WIDTH-1:0] pattern_in,
    output logic [BUSES*LANE_WIDTH-1:0] pattern_out,
    output logic interface_reset_n,
    output logic output_power_en,
    output logic clock_gate_en,
    output logic [1:0] sample_width_select,
    output logic [11:0] sample_mask,
    output logic interleave_single,
    output logic bus_timing_align,
    output logic bus_demux_factor,
    output logic [3:0] active_bus_mask,
    output logic lane_pattern_sel,
    output logic frame_strobe,
    output logic sync_request
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    generate
        if (BUSES != 4) begin : g_bad_buses
            $error("lvds_interface_control serves exactly four buses");
        end
        if (LANE_WIDTH < 12) begin : g_bad_width
            $error("lvds_interface_control needs lanes of 12 bits or more");
        end
    endgenerate

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [7:0] test_pattern_control;
    logic [7:0] output_interface_enable;
    logic [7:0] output_mode;
    logic [7:0] frame_length;
    logic [7:0] manual_sync_request;
    logic [7:0] output_control;
    logic [7:0] frame_count;
    logic [7:0] status_word;

    // ----------------------------------------
    // Bus address phase
    // ----------------------------------------
    logic ph_valid;
    logic ph_write;
    logic [11:0] ph_index;
    logic a_take;
    logic a_hit;
    logic [11:0] a_index;
    logic wr_en;
    logic [31:0] next_rdata;
    logic [7:0] rd_byte;

    assign a_take = hsel & hready & htrans[1];
    assign a_index = haddr[13:2];
    // Unmapped high or misaligned addresses never reach a register
    assign a_hit = (haddr[31:14] == 18'h0_0000) & (haddr[1:0] == 2'h0);
    assign wr_en = ph_valid & ph_write;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_index <= 12'h000;
        end else if (hready) begin
            ph_valid <= a_take & a_hit;
            ph_write <= hwrite;
            ph_index <= a_index;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            test_pattern_control <= lvds_ctrl_pkg::RST_PATTERN_CTRL; // R2
        end else if (wr_en &&
            ph_index == lvds_ctrl_pkg::IDX_PATTERN_CTRL) begin
            test_pattern_control <= hwdata[7:0]; // R21
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            output_interface_enable <= lvds_ctrl_pkg::RST_ENABLE; // R7
        end else if (wr_en && ph_index == lvds_ctrl_pkg::IDX_ENABLE) begin
            output_interface_enable <= hwdata[7:0]; // R7
        end
    end

    // Writes land even while enabled; ordering is left to software
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            output_mode <= lvds_ctrl_pkg::RST_MODE; // R12
        end else if (wr_en && ph_index == lvds_ctrl_pkg::IDX_MODE) begin
            output_mode <= hwdata[7:0]; // R21
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_length <= lvds_ctrl_pkg::RST_FRAME_LEN; // R13
        end else if (wr_en && ph_index == lvds_ctrl_pkg::IDX_FRAME_LEN) begin
            frame_length <= hwdata[7:0]; // R13
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            manual_sync_request <= lvds_ctrl_pkg::RST_SYNC_REQ; // R17
        end else if (wr_en && ph_index == lvds_ctrl_pkg::IDX_SYNC_REQ) begin
            manual_sync_request <= hwdata[7:0]; // R17
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            output_control <= lvds_ctrl_pkg::RST_OUT_CTRL;
        end else if (wr_en && ph_index == lvds_ctrl_pkg::IDX_OUT_CTRL) begin
            output_control <= hwdata[7:0]; // R21
        end
    end

    // ----------------------------------------
    // Field decode
    // ----------------------------------------
    logic enabled;
    logic demux2;
    logic [1:0] sync_sel;
    logic [1:0] width_sel;
    logic soft_sync_n;

    assign enabled = output_interface_enable[lvds_ctrl_pkg::ENABLE_BIT];
    assign demux2 = output_mode[lvds_ctrl_pkg::DEMUX_BIT];
    assign width_sel =
        output_mode[lvds_ctrl_pkg::WIDTH_MSB:lvds_ctrl_pkg::WIDTH_LSB];
    assign sync_sel =
        output_control[lvds_ctrl_pkg::SYNC_SEL_MSB:lvds_ctrl_pkg::SYNC_SEL_LSB];
    assign soft_sync_n = manual_sync_request[lvds_ctrl_pkg::SOFT_SYNC_N_BIT];

    // ----------------------------------------
    // Configuration outputs
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            interface_reset_n <= 1'b0;
            output_power_en <= 1'b0;
            clock_gate_en <= 1'b0;
        end else begin
            interface_reset_n <= enabled; // R4
            output_power_en <= enabled; // R4
            clock_gate_en <= enabled; // R4
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sample_width_select <= 2'h0;
            interleave_single <= 1'b0;
            bus_timing_align <= 1'b0;
            bus_demux_factor <= 1'b0;
            lane_pattern_sel <= 1'b0;
        end else begin
            sample_width_select <= width_sel; // R8
            interleave_single <=
                output_mode[lvds_ctrl_pkg::INTERLEAVE_BIT]; // R9
            bus_timing_align <= output_mode[lvds_ctrl_pkg::ALIGN_BIT]; // R11
            bus_demux_factor <= demux2; // R12
            lane_pattern_sel <=
                test_pattern_control[lvds_ctrl_pkg::LANE_PAT_BIT];
        end
    end

    // Truncation keeps the most significant bits of each sample
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sample_mask <= 12'h000;
        end else begin
            case (width_sel)
                lvds_ctrl_pkg::WIDTH_12:
                    sample_mask <= lvds_ctrl_pkg::MASK_12; // R8
                lvds_ctrl_pkg::WIDTH_11:
                    sample_mask <= lvds_ctrl_pkg::MASK_11; // R8
                lvds_ctrl_pkg::WIDTH_10:
                    sample_mask <= lvds_ctrl_pkg::MASK_10; // R8
                default: sample_mask <= lvds_ctrl_pkg::MASK_8; // R8
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            active_bus_mask <= 4'h0;
        end else if (!enabled) begin
            active_bus_mask <= 4'h0; // R4
        end else if (demux2) begin
            active_bus_mask <= lvds_ctrl_pkg::BUSES_DEMUX2; // R12
        end else begin
            active_bus_mask <= lvds_ctrl_pkg::BUSES_DEMUX1; // R12
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [3:0] pins_sync;
    logic link_s;
    logic sysref_s;
    logic se_n_s;
    logic ts_n_s;

    // Active-low sync pins idle high through reset
    level_sync #(
        .WIDTH(4),
        .RESET_VAL(4'hC)
    ) u_pin_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .async_in({tmstp_sync_n, sync_se_n, sysref, link_clk}),
        .sync_out(pins_sync)
    );

    assign link_s = pins_sync[0];
    assign sysref_s = pins_sync[1];
    assign se_n_s = pins_sync[2];
    assign ts_n_s = pins_sync[3];

    // ----------------------------------------
    // Sync request
    // ----------------------------------------
    logic pin_req;

    always_comb begin
        case (sync_sel)
            lvds_ctrl_pkg::SYNC_SEL_SINGLE: pin_req = ~se_n_s; // R20
            lvds_ctrl_pkg::SYNC_SEL_TSTAMP: pin_req = ~ts_n_s; // R20
            default: pin_req = 1'b0; // R19
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_request <= 1'b0;
        end else begin
            sync_request <= ~soft_sync_n | pin_req; // R17 R18
        end
    end

    // ----------------------------------------
    // Unit interval and frame counter
    // ----------------------------------------
    logic link_q;
    logic sysref_q;
    logic link_rise;
    logic sysref_rise;
    logic ui_half;
    logic ui_tick;
    logic frame_end;

    assign link_rise = link_s & ~link_q;
    assign sysref_rise = sysref_s & ~sysref_q;
    assign ui_tick = link_rise & (~demux2 | ui_half); // R15
    // Length 0 wraps at 256; unsupported lengths are not trapped
    assign frame_end = frame_count == (frame_length - 8'h01);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            link_q <= 1'b0;
            sysref_q <= 1'b0;
        end else begin
            link_q <= link_s;
            sysref_q <= sysref_s;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ui_half <= 1'b0;
        end else if (!enabled || sysref_rise) begin
            ui_half <= 1'b0; // R4
        end else if (link_rise && demux2) begin
            ui_half <= ~ui_half; // R15
        end else if (!demux2) begin
            ui_half <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_count <= 8'h00;
        end else if (!enabled) begin
            frame_count <= 8'h00; // R5
        end else if (sysref_rise) begin
            frame_count <= 8'h00;
        end else if (ui_tick && frame_end) begin
            frame_count <= 8'h00; // R14
        end else if (ui_tick) begin
            frame_count <= frame_count + 8'h01; // R14
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_strobe <= 1'b0;
        end else if (!enabled) begin
            frame_strobe <= 1'b0; // R5
        end else begin
            frame_strobe <= ui_tick & frame_end; // R14
        end
    end

    // ----------------------------------------
    // Test pattern lanes
    // ----------------------------------------
    generate
        for (genvar b = 0; b < BUSES; b++) begin : g_lane
            pattern_lane_invert #(
                .WIDTH(LANE_WIDTH),
                .INV_BIT(lvds_ctrl_pkg::INV_FIRST_DATA_BIT + b)
            ) u_lane (
                .core_clk(core_clk),
                .arst_n(arst_n),
                .lane_on(active_bus_mask[b]), // R4
                .invert(
                    test_pattern_control[lvds_ctrl_pkg::INV_A_BIT + b]
                ), // R1 R2
                .word_in(pattern_in[b*LANE_WIDTH +: LANE_WIDTH]),
                .word_out(pattern_out[b*LANE_WIDTH +: LANE_WIDTH])
            );
        end
    endgenerate

    // ----------------------------------------
    // Status and read path
    // ----------------------------------------
    always_comb begin
        status_word = 8'h00;
        status_word[lvds_ctrl_pkg::STAT_SYNC_BIT] = sync_request;
        status_word[lvds_ctrl_pkg::STAT_RUN_BIT] = interface_reset_n;
    end

    always_comb begin
        case (a_index)
            lvds_ctrl_pkg::IDX_PATTERN_CTRL: rd_byte = test_pattern_control;
            lvds_ctrl_pkg::IDX_ENABLE: rd_byte = output_interface_enable;
            lvds_ctrl_pkg::IDX_MODE: rd_byte = output_mode;
            lvds_ctrl_pkg::IDX_FRAME_LEN: rd_byte = frame_length;
            lvds_ctrl_pkg::IDX_SYNC_REQ: rd_byte = manual_sync_request;
            lvds_ctrl_pkg::IDX_OUT_CTRL: rd_byte = output_control;
            lvds_ctrl_pkg::IDX_FRAME_COUNT: rd_byte = frame_count;
            lvds_ctrl_pkg::IDX_STATUS: rd_byte = status_word;
            default: rd_byte = 8'h00;
        endcase
        // Forward a write in its data phase to a read right behind it
        if (wr_en && ph_index == a_index &&
            a_index != lvds_ctrl_pkg::IDX_FRAME_COUNT &&
            a_index != lvds_ctrl_pkg::IDX_STATUS) begin
            rd_byte = hwdata[7:0];
        end
        next_rdata = {24'h00_0000, rd_byte};
        if (!a_hit) begin
            next_rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (a_take && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

endmodule

// ### rtl/pattern_lane_invert.sv
`timescale 1ns/1ps
module pattern_lane_invert #(
    parameter int WIDTH = 12,
    parameter int INV_BIT = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic lane_on,
    input wire logic invert,
    input wire logic [WIDTH-1:0] word_in,
    output logic [WIDTH-1:0] word_out
);
    logic [WIDTH-1:0] flip;

    always_comb begin
        flip = '0;
        flip[INV_BIT] = invert;
    end

    // ----------------------------------------
    // Registered lane, quiet while off
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            word_out <= '0;
        end else if (lane_on) begin
            word_out <= word_in ^ flip;
        end else begin
            word_out <= '0;
        end
    end
endmodule

// ### testbench/link_source_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far side: link clock and sync pins
// ----------------------------------------
module link_source_model (
    input wire logic run,
    input wire logic se_low,
    input wire logic ts_low,
    output logic link_clk,
    output logic sysref,
    output logic sync_se_n,
    output logic tmstp_sync_n
);
    // Clock parks low while run is low; odd offset keeps phase unrelated
    initial begin
        link_clk = 1'b0;
        #7;
        forever begin
            #160;
            link_clk = run ? ~link_clk : 1'b0;
        end
    end
    assign sysref = 1'b0;
    assign sync_se_n = ~se_low;
    assign tmstp_sync_n = ~ts_low;
endmodule

// ### testbench/lvds_interface_control_monitor.sv
`timescale 1ns/1ps
module lvds_interface_control_monitor #(
    parameter int LANE_WIDTH = 12,
    parameter int BUSES = 4
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [BUSES*LANE_WIDTH-1:0] pattern_in,
    input wire logic [BUSES*LANE_WIDTH-1:0] pattern_out,
    input wire logic interface_reset_n,
    input wire logic output_power_en,
    input wire logic clock_gate_en,
    input wire logic [1:0] sample_width_select,
    input wire logic [11:0] sample_mask,
    input wire logic bus_demux_factor,
    input wire logic [3:0] active_bus_mask,
    input wire logic frame_strobe,
    input wire logic sync_request
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_hold_off: assert property (
        output_power_en == interface_reset_n && clock_gate_en == interface_reset_n)
        else $error("power or gate not tied to enable");
    chk_pattern_gate: assert property (
        !interface_reset_n && $past(!interface_reset_n) |-> pattern_out == '0)
        else $error("pattern driven while disabled");
    chk_bus_count: assert property (
        interface_reset_n && $past(interface_reset_n) |->
        active_bus_mask == (bus_demux_factor ? 4'hF : 4'h3))
        else $error("active buses disagree with demux");
    chk_width_mask: assert property (
        interface_reset_n && $past(interface_reset_n) |->
        sample_mask == (sample_width_select == 2'h0 ? 12'hFFF :
        sample_width_select == 2'h1 ? 12'hFFE :
        sample_width_select == 2'h2 ? 12'hFFC : 12'hFF0))
        else $error("sample mask wrong for width");
    chk_strobe_pulse: assert property (
        frame_strobe |=> !frame_strobe [*3])
        else $error("strobe longer than a pulse");
    chk_strobe_off: assert property (
        !interface_reset_n && $past(!interface_reset_n) |-> !frame_strobe)
        else $error("strobe while disabled");
    chk_inv_a_only: assert property (
        $past(active_bus_mask[0]) |-> ((pattern_out[0 +: 12] ^
        $past(pattern_in[0 +: 12])) & 12'hEFF) == 12'h000)
        else $error("bus a bits other than 8 altered");
    chk_inv_b_only: assert property (
        $past(active_bus_mask[1]) |-> ((pattern_out[LANE_WIDTH +: 12] ^
        $past(pattern_in[LANE_WIDTH +: 12])) & 12'hDFF) == 12'h000)
        else $error("bus b bits other than 9 altered");
    cover property (frame_strobe);
    cover property ($fell(interface_reset_n));
    cover property ($rose(sync_request));
endmodule
bind lvds_interface_control lvds_interface_control_monitor #(
    .LANE_WIDTH(LANE_WIDTH), .BUSES(BUSES)) mon (.*);

// ### testbench/lvds_interface_control_tb_top.sv
`timescale 1ns/1ps
module lvds_interface_control_tb_top;
    logic core_clk = 0, arst_n = 0, hsel = 0, hwrite = 0;
    logic run = 0, se_low = 0, ts_low = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = '0, sample_width_select;
    logic [2:0] hsize = 3'h2;
    logic [47:0] pattern_in = '0, pattern_out, pin;
    logic hreadyout, hresp, link_clk, sysref, sync_se_n, tmstp_sync_n;
    logic interface_reset_n, output_power_en, clock_gate_en, frame_strobe;
    logic interleave_single, bus_timing_align, bus_demux_factor;
    logic lane_pattern_sel, sync_request;
    logic [11:0] sample_mask;
    logic [3:0] active_bus_mask;
    logic [1:0] w;
    logic [7:0] v;
    int n_errors = 0, cmp_count = 0, cycles = 0, n;
    logic [31:0] ra [6] = '{32'h0000_0640, 32'h0000_0800, 32'h0000_0804,
        32'h0000_0808, 32'h0000_080C, 32'h0000_0810};
    logic [7:0] rv [6] = '{8'h1E, 8'h01, 8'h01, 8'h80, 8'h01, 8'h02};
    logic [11:0] mk [4] = '{12'hFFF, 12'hFFE, 12'hFFC, 12'hFF0};

    always #20 core_clk = ~core_clk;

    lvds_interface_control uut (.hready(hreadyout), .*);

    link_source_model far (.*);

    // ----------------------------------------
    // Bus tasks and compare
    // ----------------------------------------
    task automatic bus_xfer(input logic [31:0] a, input logic wr,
        input logic [7:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Writes only while disabled, as software must; no calibration here
    task automatic cfg(input logic [31:0] a, input logic [7:0] d);
        bus_xfer(32'h0000_0800, 1'b1, 8'h00);
        bus_xfer(a, 1'b1, d);
        bus_xfer(32'h0000_0800, 1'b1, 8'h01);
        repeat (3) @(posedge core_clk);
    endtask

    // First strobe may come early after a reconfigure, so time the second
    task automatic period(input int exp);
        n = 0;
        do @(posedge core_clk); while (frame_strobe !== 1'b1 && ++n < 1000);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (frame_strobe !== 1'b1 && n < 1000);
        check(n, exp);
    endtask

    task automatic end_sim;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        run <= 1'b1;
        repeat (2) @(posedge core_clk);
        check({interface_reset_n, output_power_en, clock_gate_en}, 3'h7);
        for (int i = 0; i < 6; i++) begin
            bus_xfer(ra[i], 1'b0, 8'h00);
            check(rd, rv[i]);
        end
        bus_xfer(32'h0000_0900, 1'b1, 8'h5A);
        bus_xfer(32'h0000_0900, 1'b0, 8'h00);
        check(rd, 32'h0000_0000);
        bus_xfer(32'h0000_0800, 1'b1, 8'h00);
        repeat (3) @(posedge core_clk);
        check({interface_reset_n, active_bus_mask, pattern_out}, '0);
        for (int i = 0; i < 4; i++) begin
            w = i[1:0];
            v = {2'b11, w, 1'b1, w[0], w[1], ~w[0]};
            cfg(32'h0000_0804, v);
            check(sample_width_select, w);
            check(sample_mask, mk[i]);
            check(interleave_single, w[0]);
            check(bus_timing_align, w[1]);
            check(active_bus_mask, w[0] ? 4'h3 : 4'hF);
            bus_xfer(32'h0000_0804, 1'b0, 8'h00);
            check(rd, v);
        end
        cfg(32'h0000_0808, 8'h08);
        period(64);
        cfg(32'h0000_0804, 8'h01);
        cfg(32'h0000_0808, 8'h0C);
        period(192);
        pin = 48'hA5C3_5A3C_96E1;
        pattern_in <= pin;
        cfg(32'h0000_0640, 8'h03);
        check(pattern_out, pin ^ 48'h0000_0020_0100);
        cfg(32'h0000_0804, 8'h00);
        check(pattern_out, {24'h00_0000, pin[23:0] ^ 24'h20_0100});
        bus_xfer(32'h0000_0800, 1'b1, 8'h00);
        n = 0;
        repeat (300) @(posedge core_clk) n += int'(frame_strobe === 1'b1);
        check(n, 0);
        run <= 1'b0;
        for (int s = 0; s < 3; s++) begin
            bus_xfer(32'h0000_0810, 1'b1, 8'(s << 2) | 8'h02);
            for (int p = 0; p < 2; p++) begin
                se_low <= (p == 0);
                ts_low <= (p == 1);
                repeat (5) @(posedge core_clk);
                check(sync_request, s == p);
            end
            se_low <= 1'b0;
            ts_low <= 1'b0;
        end
        bus_xfer(32'h0000_080C, 1'b1, 8'h00);
        repeat (2) @(posedge core_clk);
        check(sync_request, 1'b1);
        bus_xfer(32'h0000_080C, 1'b1, 8'h01);
        repeat (2) @(posedge core_clk);
        check(sync_request, 1'b0);
        end_sim();
    end
endmodule
